// [src/adrc_top.sv]
// Operation
// - Host termination of a burst negates the DMA request early.
// - Reads negate the DMA request after every 8 Mbytes moved.
// - Otherwise the request stays asserted until the transfer completes.
// - Writes negate early only on host termination, never at segments.
// - USB packet errors never drop an asserted DMA request.
// - Persistent NAK on command block: no request, busy set, data request clear.
// - Persistent NAK on first bulk-in before any ack: same as command block case.
// - NAK after an acked bulk-in: request held, busy clear, data request set.
// - NAK on status stage: burst ends, busy set, data request clear.
// - Writes follow the same NAK dependent request and status behaviour.
// - Straps low select IDE bus, ATAPI commands and single device mode.
// - Master/slave select low answers as master, high as slave.
// - At most two storage devices served, further ones ignored.
// - At most three hubs accepted, further ones ignored.
// - Storage behind a full-speed hub runs at full speed.
// - Floppy subclass storage devices are not supported.
// - Storage of 137 GB or more uses extended large-drive addressing.
// - Processor DMA uses active low request and acknowledge.

module adrc_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic full_q, full_d, empty_q, empty_d;
    logic push, pop;

    // ------------------------------------------------------------
    // Pointers and flags
    // ------------------------------------------------------------
    always_comb begin
        push = in_valid && !full_q;
        pop = out_ready && !empty_q;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        full_d = cnt_d == DEPTH[AW:0];
        empty_d = cnt_d == '0;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            empty_q <= empty_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = !full_q;
    assign out_valid = !empty_q;
    assign out_data = mem_q[rd_q];
endmodule

module adrc_top #(
    parameter int unsigned FIFO_DEPTH = adrc_pkg::FIFO_DEPTH,
    parameter logic [adrc_pkg::SEG_W-1:0] SEG_LEN = adrc_pkg::SEG_BYTES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire adrc_pkg::adrc_strap_t strap_pins,
    output logic ide_mode_q,
    output logic atapi_mode_q,
    output logic single_dev_mode_q,
    output logic slave_role_q,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_dev_slave,
    input wire logic [adrc_pkg::LEN_W-1:0] cmd_len,
    output logic cmd_reject_q,
    input wire logic dmack_n,
    input wire logic host_stop,
    input wire logic host_stb,
    input wire logic [adrc_pkg::WORD_W-1:0] host_wdata,
    output logic dmarq_n_q,
    output logic [adrc_pkg::WORD_W-1:0] host_rdata_q,
    output logic bsy_q,
    output logic drq_q,
    input wire logic usb_cbw_ack,
    input wire logic usb_data_ack,
    input wire logic usb_csw_ok,
    input wire logic usb_nak_stuck,
    input wire logic usb_pkt_err,
    input wire logic usb_rx_valid,
    input wire logic [adrc_pkg::WORD_W-1:0] usb_rx_data,
    output logic usb_rx_ready_q,
    output logic usb_tx_valid_q,
    output logic [adrc_pkg::WORD_W-1:0] usb_tx_data_q,
    output logic pkt_err_seen_q,
    input wire logic dev_attach,
    input wire adrc_pkg::adrc_dev_t dev_info,
    output logic dev_accept_q,
    output logic dev_slot_slave_q,
    output logic dev_fs_only_q,
    output logic dev_lba48_q
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int unsigned PW = 7 + adrc_pkg::WORD_W;
    logic [PW-1:0] pin_s1_q, pin_s2_q;
    logic stb_s3_q;
    logic dmack_s, stop_s, stb_edge;
    logic [adrc_pkg::WORD_W-1:0] wdata_s;
    adrc_pkg::adrc_strap_t strap_s;

    always_ff @(posedge core_clk) begin
        pin_s1_q <= {strap_pins, dmack_n, host_stop, host_stb, host_wdata};
        pin_s2_q <= pin_s1_q;
        stb_s3_q <= pin_s2_q[adrc_pkg::WORD_W];
    end

    always_comb begin
        {strap_s, dmack_s, stop_s} = pin_s2_q[PW-1:adrc_pkg::WORD_W+1];
        dmack_s = !dmack_s;
        stb_edge = pin_s2_q[adrc_pkg::WORD_W] && !stb_s3_q;
        wdata_s = pin_s2_q[adrc_pkg::WORD_W-1:0];
    end

    // ------------------------------------------------------------
    // Transfer control
    // ------------------------------------------------------------
    adrc_pkg::adrc_state_t state_q, state_d;
    logic wr_q, wr_d, rej_d, err_d, rx_rdy_d, txv_d;
    logic dmarq_n_d, bsy_d, drq_d;
    logic [adrc_pkg::LEN_W-1:0] left_q, left_d;
    logic [adrc_pkg::SEG_W-1:0] seg_q, seg_d;
    logic [adrc_pkg::WORD_W-1:0] rdata_d, txd_d;
    logic f_valid, f_ready, f_in_ready, xfer, seg_hit;
    logic [adrc_pkg::WORD_W-1:0] f_data;

    adrc_fifo #(.WIDTH(adrc_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(usb_rx_valid),
        .in_ready(f_in_ready),
        .in_data(usb_rx_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    always_comb begin
        state_d = state_q;
        wr_d = wr_q;
        left_d = left_q;
        seg_d = seg_q;
        rdata_d = host_rdata_q;
        txd_d = usb_tx_data_q;
        txv_d = 1'b0;
        rej_d = 1'b0;
        err_d = pkt_err_seen_q || usb_pkt_err;
        xfer = state_q == adrc_pkg::ADRC_BURST && dmack_s && stb_edge && !stop_s && (wr_q || f_valid);
        f_ready = xfer && !wr_q;
        seg_hit = 1'b0;
        unique case (state_q)
            adrc_pkg::ADRC_IDLE: begin
                if (cmd_valid && cmd_dev_slave == slave_role_q) begin
                    if (cmd_write && cmd_len > adrc_pkg::WR_MAX_BYTES) begin
                        rej_d = 1'b1;
                    end else if (cmd_len != '0) begin
                        state_d = adrc_pkg::ADRC_CBW;
                        wr_d = cmd_write;
                        left_d = cmd_len;
                        seg_d = '0;
                        err_d = usb_pkt_err;
                    end
                end
            end
            adrc_pkg::ADRC_CBW: begin
                if (usb_cbw_ack && !usb_nak_stuck) begin
                    state_d = wr_q ? adrc_pkg::ADRC_BURST : adrc_pkg::ADRC_FIRST_IN;
                end
            end
            adrc_pkg::ADRC_FIRST_IN: begin
                if (usb_data_ack && !usb_nak_stuck) begin
                    state_d = adrc_pkg::ADRC_BURST;
                end
            end
            adrc_pkg::ADRC_BURST: begin
                if (stop_s) begin
                    state_d = adrc_pkg::ADRC_SEG_GAP;
                end else if (xfer) begin
                    left_d = left_q - adrc_pkg::WORD_BYTES;
                    seg_d = seg_q + adrc_pkg::WORD_BYTES[adrc_pkg::SEG_W-1:0];
                    if (wr_q) begin
                        txd_d = wdata_s;
                        txv_d = 1'b1;
                    end else begin
                        rdata_d = f_data;
                    end
                    if (left_d == '0) begin
                        state_d = adrc_pkg::ADRC_CSW;
                    end else if (!wr_q && seg_d == SEG_LEN) begin
                        seg_hit = 1'b1;
                        seg_d = '0;
                        state_d = adrc_pkg::ADRC_SEG_GAP;
                    end
                end
            end
            adrc_pkg::ADRC_SEG_GAP: begin
                if (!dmack_s && !stop_s) begin
                    state_d = adrc_pkg::ADRC_BURST;
                end
            end
            adrc_pkg::ADRC_CSW: begin
                if (usb_csw_ok && !usb_nak_stuck) begin
                    state_d = adrc_pkg::ADRC_IDLE;
                end
            end
            default: state_d = adrc_pkg::ADRC_IDLE;
        endcase
        dmarq_n_d = state_d != adrc_pkg::ADRC_BURST;
        bsy_d = state_d inside {adrc_pkg::ADRC_CBW, adrc_pkg::ADRC_FIRST_IN, adrc_pkg::ADRC_CSW};
        drq_d = state_d inside {adrc_pkg::ADRC_BURST, adrc_pkg::ADRC_SEG_GAP};
        rx_rdy_d = f_in_ready && !(f_valid && !f_ready && !f_in_ready);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= adrc_pkg::ADRC_IDLE;
            wr_q <= 1'b0;
            left_q <= '0;
            seg_q <= '0;
            host_rdata_q <= '0;
            usb_tx_data_q <= '0;
            usb_tx_valid_q <= 1'b0;
            cmd_reject_q <= 1'b0;
            pkt_err_seen_q <= 1'b0;
            dmarq_n_q <= 1'b1;
            bsy_q <= 1'b0;
            drq_q <= 1'b0;
            usb_rx_ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wr_q <= wr_d;
            left_q <= left_d;
            seg_q <= seg_d;
            host_rdata_q <= rdata_d;
            usb_tx_data_q <= txd_d;
            usb_tx_valid_q <= txv_d;
            cmd_reject_q <= rej_d;
            pkt_err_seen_q <= err_d;
            dmarq_n_q <= dmarq_n_d;
            bsy_q <= bsy_d;
            drq_q <= drq_d;
            usb_rx_ready_q <= rx_rdy_d;
        end
    end

    // ------------------------------------------------------------
    // Straps and attached devices
    // ------------------------------------------------------------
    logic [1:0] stor_q, stor_d, hub_q, hub_d;
    logic acc_d, slot_d, fs_d, lba_d, ide_d, atapi_d, single_d, slave_d;

    always_comb begin
        stor_d = stor_q;
        hub_d = hub_q;
        acc_d = 1'b0;
        slot_d = dev_slot_slave_q;
        fs_d = dev_fs_only_q;
        lba_d = dev_lba48_q;
        ide_d = !strap_s.host_bus_type_select;
        atapi_d = !strap_s.command_set_select;
        single_d = !strap_s.device_count_select;
        slave_d = strap_s.master_slave_select;
        if (dev_attach) begin
            if (dev_info.is_hub) begin
                if (hub_q < adrc_pkg::MAX_HUBS) begin
                    hub_d = hub_q + 2'h1;
                    acc_d = 1'b1;
                end
            end else if (!dev_info.is_ufi && stor_q < adrc_pkg::MAX_STORAGE) begin
                stor_d = stor_q + 2'h1;
                acc_d = 1'b1;
                slot_d = stor_q[0];
                fs_d = dev_info.via_fs_hub;
                lba_d = dev_info.sectors >= adrc_pkg::BIG_DRIVE_SECTORS;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stor_q <= '0;
            hub_q <= '0;
            dev_accept_q <= 1'b0;
            dev_slot_slave_q <= 1'b0;
            dev_fs_only_q <= 1'b0;
            dev_lba48_q <= 1'b0;
            ide_mode_q <= 1'b0;
            atapi_mode_q <= 1'b0;
            single_dev_mode_q <= 1'b0;
            slave_role_q <= 1'b0;
        end else begin
            stor_q <= stor_d;
            hub_q <= hub_d;
            dev_accept_q <= acc_d;
            dev_slot_slave_q <= slot_d;
            dev_fs_only_q <= fs_d;
            dev_lba48_q <= lba_d;
            ide_mode_q <= ide_d;
            atapi_mode_q <= atapi_d;
            single_dev_mode_q <= single_d;
            slave_role_q <= slave_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    burst_request_a: assert property (state_q == adrc_pkg::ADRC_BURST |-> !dmarq_n_q && !bsy_q && drq_q)
        else $error("request or status wrong in burst");
    nak_hold_a: assert property ((state_q inside {adrc_pkg::ADRC_CBW, adrc_pkg::ADRC_FIRST_IN}) && usb_nak_stuck
        |=> dmarq_n_q && bsy_q && !drq_q)
        else $error("request raised under command nak");
    csw_status_a: assert property (state_q == adrc_pkg::ADRC_CSW && usb_nak_stuck |=> dmarq_n_q && bsy_q && !drq_q)
        else $error("status stage nak status wrong");
    host_term_a: assert property (state_q == adrc_pkg::ADRC_BURST && stop_s |=> dmarq_n_q)
        else $error("request kept after host stop");
    seg_negate_a: assert property (seg_hit |=> dmarq_n_q && state_q == adrc_pkg::ADRC_SEG_GAP)
        else $error("no negation at segment boundary");
    seg_resume_a: assert property (state_q == adrc_pkg::ADRC_SEG_GAP && !dmack_s && !stop_s |=> !dmarq_n_q)
        else $error("request not restored after segment");
    write_no_seg_a: assert property (wr_q && xfer && !stop_s |=> state_q != adrc_pkg::ADRC_SEG_GAP)
        else $error("write negated at segment");
    len_track_a: assert property (xfer |=> left_q == $past(left_q) - adrc_pkg::WORD_BYTES)
        else $error("remaining length not decremented");
    err_keep_a: assert property (usb_pkt_err && state_q == adrc_pkg::ADRC_BURST && !xfer && !stop_s |=> !dmarq_n_q)
        else $error("packet error dropped request");
    dev_limit_a: assert property (stor_q <= adrc_pkg::MAX_STORAGE && hub_q <= adrc_pkg::MAX_HUBS)
        else $error("device count over limit");
    strap_mode_a: assert property (!$past(reset) |-> ide_mode_q == !$past(strap_s.host_bus_type_select))
        else $error("bus mode strap not followed");

    read_seg_c: cover property (seg_hit ##[1:50] !dmarq_n_q);
    write_done_c: cover property (wr_q && state_q == adrc_pkg::ADRC_CSW ##[1:20] state_q == adrc_pkg::ADRC_IDLE);
    nak_cbw_c: cover property ((state_q == adrc_pkg::ADRC_CBW && usb_nak_stuck) [*4]);
endmodule

// [src/adrc_pkg.sv]
package adrc_pkg;
    // ------------------------------------------------------------
    // Sizes and limits
    // ------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned LEN_W = 32;
    localparam int unsigned SEG_W = 24;
    localparam logic [SEG_W-1:0] SEG_BYTES = 24'h800000;
    localparam logic [LEN_W-1:0] WORD_BYTES = 32'h00000002;
    localparam logic [LEN_W-1:0] WR_MAX_BYTES = 32'h00800000;
    localparam logic [47:0] BIG_DRIVE_SECTORS = 48'h000010000000;
    localparam logic [1:0] MAX_STORAGE = 2'h2;
    localparam logic [1:0] MAX_HUBS = 2'h3;
    localparam int unsigned FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ADRC_IDLE = 3'h0,
        ADRC_CBW = 3'h1,
        ADRC_FIRST_IN = 3'h2,
        ADRC_BURST = 3'h3,
        ADRC_SEG_GAP = 3'h4,
        ADRC_CSW = 3'h5
    } adrc_state_t;

    typedef struct packed {
        logic host_bus_type_select;
        logic command_set_select;
        logic device_count_select;
        logic master_slave_select;
    } adrc_strap_t;

    typedef struct packed {
        logic is_hub;
        logic is_ufi;
        logic via_fs_hub;
        logic [47:0] sectors;
    } adrc_dev_t;
endpackage

// [verification/adrc_host_model.sv]
module adrc_host_model (
    input wire logic core_clk,
    input wire logic dmarq_n,
    output logic dmack_n,
    output logic host_stb,
    output logic [15:0] host_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Host side of the DMA handshake
    // ----------------------------------------
    initial begin
        dmack_n = 1'b1;
        host_stb = 1'b0;
        host_wdata = 16'h0;
    end

    task automatic xfer(input logic [15:0] w, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        while (dmarq_n !== 1'b0 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (dmarq_n === 1'b0) begin
            ok = 1'b1;
            dmack_n = 1'b0;
            host_wdata = w;
            repeat (4) @(negedge core_clk);
            host_stb = 1'b1;
            repeat (4) @(negedge core_clk);
            host_stb = 1'b0;
            repeat (4) @(negedge core_clk);
            host_wdata = ~w;
        end
    endtask

    task automatic release_ack;
        dmack_n = 1'b1;
        host_wdata = ~host_wdata;
    endtask
endmodule

// [verification/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    adrc_pkg::adrc_strap_t strap_pins = '0;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_dev_slave = 1'b0, host_stop = 1'b0;
    logic [31:0] cmd_len = 32'h0;
    logic usb_cbw_ack = 1'b0, usb_data_ack = 1'b0, usb_csw_ok = 1'b0, usb_nak_stuck = 1'b0;
    logic usb_pkt_err = 1'b0, usb_rx_valid = 1'b0, dev_attach = 1'b0;
    logic [15:0] usb_rx_data = 16'h0;
    adrc_pkg::adrc_dev_t dev_info = '0;
    logic ide_mode_q, atapi_mode_q, single_dev_mode_q, slave_role_q, cmd_reject_q, dmarq_n_q, bsy_q, drq_q;
    logic usb_rx_ready_q, usb_tx_valid_q, pkt_err_seen_q, dev_accept_q, dev_slot_slave_q, dev_fs_only_q, dev_lba48_q;
    logic dmack_n, host_stb;
    logic [15:0] host_wdata, host_rdata_q, usb_tx_data_q;
    int errors = 0;
    int tests_run = 0;
    int rej_cnt = 0;
    int acc_cnt = 0;
    logic [15:0] exp_q[$];
    logic [15:0] tx_q[$];

    always #5 core_clk = ~core_clk;

    adrc_top #(.FIFO_DEPTH(4), .SEG_LEN(24'h000008)) u_dut (
        .core_clk, .reset, .strap_pins, .ide_mode_q, .atapi_mode_q, .single_dev_mode_q, .slave_role_q,
        .cmd_valid, .cmd_write, .cmd_dev_slave, .cmd_len, .cmd_reject_q, .dmack_n, .host_stop, .host_stb,
        .host_wdata, .dmarq_n_q, .host_rdata_q, .bsy_q, .drq_q, .usb_cbw_ack, .usb_data_ack, .usb_csw_ok,
        .usb_nak_stuck, .usb_pkt_err, .usb_rx_valid, .usb_rx_data, .usb_rx_ready_q, .usb_tx_valid_q,
        .usb_tx_data_q, .pkt_err_seen_q, .dev_attach, .dev_info, .dev_accept_q, .dev_slot_slave_q,
        .dev_fs_only_q, .dev_lba48_q
    );
    adrc_host_model u_host (.core_clk, .dmarq_n(dmarq_n_q), .dmack_n, .host_stb, .host_wdata);

    always @(negedge core_clk) begin
        if (cmd_reject_q === 1'b1) rej_cnt++;
        if (dev_accept_q === 1'b1) acc_cnt++;
        if (usb_tx_valid_q === 1'b1) tx_q.push_back(usb_tx_data_q);
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic status(input logic [2:0] e);
        chk(16'({dmarq_n_q, bsy_q, drq_q}), 16'(e), "request busy drq");
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic command(input logic wr, input logic [31:0] len);
        cmd_write = wr;
        cmd_len = len;
        cmd_valid = 1'b1;
        cyc(1);
        cmd_valid = 1'b0;
        cyc(2);
    endtask

    task automatic push;
        int n;
        logic [15:0] w;
        n = 0;
        w = 16'($urandom);
        while (usb_rx_ready_q !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        usb_rx_data = w;
        usb_rx_valid = 1'b1;
        cyc(1);
        usb_rx_valid = 1'b0;
        usb_rx_data = ~w;
        cyc(1);
        exp_q.push_back(w);
    endtask

    task automatic host_read(input int n);
        bit ok;
        repeat (n) begin
            u_host.xfer(16'h0, ok);
            chk(16'(ok), 16'h1, "read strobe taken");
            chk(host_rdata_q, exp_q.pop_front(), "read word");
        end
    endtask

    task automatic host_write(input int n);
        bit ok;
        logic [15:0] w;
        repeat (n) begin
            w = 16'($urandom);
            u_host.xfer(w, ok);
            chk(16'(tx_q.size()), 16'h1, "write count");
            if (tx_q.size() > 0) chk(tx_q.pop_front(), w, "write word");
        end
    endtask

    task automatic att(input logic h, input logic u, input logic f, input logic [47:0] s, input int e);
        int a0;
        a0 = acc_cnt;
        dev_info = '{is_hub: h, is_ufi: u, via_fs_hub: f, sectors: s};
        pulse(dev_attach);
        cyc(4);
        chk(16'(acc_cnt - a0), 16'(e), "attach accepted");
    endtask

    task automatic stop_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        #500us;
        errors++;
        stop_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int rej;
        void'($urandom(3969));
        cyc(8);
        reset = 1'b0;
        for (int i = 0; i < 16; i++) begin
            strap_pins = adrc_pkg::adrc_strap_t'(4'(i));
            cyc(5);
            chk(16'({ide_mode_q, atapi_mode_q, single_dev_mode_q, slave_role_q}), 16'(4'(i) ^ 4'he), "straps");
        end
        strap_pins = '0;
        cyc(5);
        command(1'b0, 32'h0000000a);
        status(3'h6);
        pulse(usb_cbw_ack);
        cyc(2);
        pulse(usb_data_ack);
        cyc(3);
        status(3'h1);
        repeat (4) push();
        cyc(2);
        chk(16'(usb_rx_ready_q), 16'h0, "buffer full");
        host_read(1);
        host_stop = 1'b1;
        cyc(3);
        chk(16'(dmarq_n_q), 16'h1, "stop negates");
        u_host.release_ack();
        host_stop = 1'b0;
        cyc(5);
        chk(16'(dmarq_n_q), 16'h0, "request back");
        pulse(usb_pkt_err);
        cyc(3);
        chk(16'({dmarq_n_q, pkt_err_seen_q}), 16'h1, "error keeps request");
        usb_nak_stuck = 1'b1;
        cyc(4);
        status(3'h1);
        usb_nak_stuck = 1'b0;
        host_read(3);
        status(3'h5);
        u_host.release_ack();
        cyc(5);
        chk(16'(dmarq_n_q), 16'h0, "segment resumes");
        push();
        host_read(1);
        usb_nak_stuck = 1'b1;
        cyc(4);
        status(3'h6);
        usb_nak_stuck = 1'b0;
        pulse(usb_csw_ok);
        cyc(2);
        status(3'h4);
        u_host.release_ack();
        command(1'b0, 32'h00000002);
        usb_nak_stuck = 1'b1;
        cyc(6);
        status(3'h6);
        usb_nak_stuck = 1'b0;
        pulse(usb_cbw_ack);
        usb_nak_stuck = 1'b1;
        cyc(6);
        status(3'h6);
        usb_nak_stuck = 1'b0;
        pulse(usb_data_ack);
        push();
        host_read(1);
        pulse(usb_csw_ok);
        cyc(2);
        u_host.release_ack();
        rej = rej_cnt;
        command(1'b1, 32'h00800002);
        cyc(2);
        chk(16'(rej_cnt - rej), 16'h1, "oversize write refused");
        command(1'b1, 32'h0000000a);
        usb_nak_stuck = 1'b1;
        cyc(6);
        status(3'h6);
        usb_nak_stuck = 1'b0;
        pulse(usb_cbw_ack);
        cyc(3);
        status(3'h1);
        host_write(4);
        status(3'h1);
        host_write(1);
        status(3'h6);
        pulse(usb_csw_ok);
        cyc(2);
        u_host.release_ack();
        att(1'b0, 1'b1, 1'b0, 48'h000010000000, 0);
        att(1'b0, 1'b0, 1'b1, 48'h000010000000, 1);
        chk(16'({dev_slot_slave_q, dev_fs_only_q, dev_lba48_q}), 16'h3, "first drive");
        att(1'b0, 1'b0, 1'b0, 48'h00000fffffff, 1);
        chk(16'({dev_slot_slave_q, dev_fs_only_q, dev_lba48_q}), 16'h4, "second drive");
        att(1'b0, 1'b0, 1'b0, 48'h000000000100, 0);
        for (int i = 0; i < 4; i++) att(1'b1, 1'b0, 1'b0, 48'h0, int'(i < 3));
        stop_test();
    end
endmodule
